/* rtl/system_watchdog.sv */
// System watchdog with first-enable premature reset after power-on.
`timescale 1ns/1ns
// Contract
// - Any reset leaves the watchdog stopped.
// - Default expiry period is 2 ms.
// - Clearing the stop bit starts the watchdog.
// - First enable fires reset after 2 ms.
// - Stop bit survives warm reset; watchdog stays stopped.
// - Only first enable is premature; later ones normal.
module system_watchdog #(
	parameter int unsigned TIMEOUT_CYCLES = watchdog_pkg::DEFAULT_TIMEOUT_CYCLES
) (
	// Clock and resets
	input  wire logic                           ref_clk,
	input  wire logic                           rst_b,
	input  wire logic                           warm_rst_b,
	// Software control
	input  wire watchdog_pkg::wd_ctl_t          ctl,
	// Status and reset request
	output watchdog_pkg::wd_state_t             wd_state,
	output logic                                watchdog_stop_bit,
	output logic                                first_done,
	output logic [watchdog_pkg::CNT_W-1:0]      count,
	output logic                                reset_req
);
	import watchdog_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 64'(32'hFFFF_FFFF)) begin : g_bad_timeout
		$error("TIMEOUT_CYCLES must lie between 1 and the counter range.");
	end

	localparam logic [CNT_W-1:0] DEF_LOAD = CNT_W'(TIMEOUT_CYCLES - 1);

	// ----------------------------------------------------------------
	// Decoded software events
	// ----------------------------------------------------------------
	logic             enable_edge;
	logic             stop_set;
	logic             start_ok;
	logic [CNT_W-1:0] load_reg;
	logic [CNT_W-1:0] run_load;

	// A write of zero onto a set stop bit is the enable event.
	assign enable_edge = warm_rst_b && ctl.sec_wr && !ctl.stop_wdata && watchdog_stop_bit;
	assign stop_set    = warm_rst_b && ctl.sec_wr && ctl.stop_wdata;
	// An explicit restart needs the stop bit already clear and a stopped counter.
	assign start_ok    = warm_rst_b && ctl.start && !watchdog_stop_bit && !ctl.sec_wr
		&& (wd_state == WD_STOPPED);

	// ----------------------------------------------------------------
	// Stop bit in the security control register
	// ----------------------------------------------------------------
	// Of the two resets only power-on reset sets it; a warm reset leaves the written value.
	// Writes wait out a warm reset, so the bit never clears without the
	// first-enable flag seeing the enable.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			watchdog_stop_bit <= STOP_BIT_RESET;
		end else if (warm_rst_b && ctl.sec_wr) begin
			watchdog_stop_bit <= ctl.stop_wdata;
		end
	end

	// ----------------------------------------------------------------
	// First-enable tracking
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			first_done <= FIRST_RESET;
		end else if (enable_edge) begin
			first_done <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Programmed timeout
	// ----------------------------------------------------------------
	// A zero timeout is ignored because it cannot be counted.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			load_reg <= DEF_LOAD;
		end else if (ctl.load_wr && (ctl.load_value != '0)) begin
			load_reg <= ctl.load_value - CNT_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Counter and state
	// ----------------------------------------------------------------
	// The first enable ignores the programmed value and always runs the
	// default period; this is the premature restart software must absorb.
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !warm_rst_b) begin
			wd_state <= WD_STOPPED;
			count    <= '0;
			run_load <= DEF_LOAD;
		end else if (stop_set) begin
			wd_state <= WD_STOPPED;
		end else if (enable_edge) begin
			wd_state <= WD_COUNTING;
			if (!first_done) begin
				count    <= DEF_LOAD;
				run_load <= DEF_LOAD;
			end else begin
				count    <= load_reg;
				run_load <= load_reg;
			end
		end else if (start_ok) begin
			wd_state <= WD_COUNTING;
			count    <= load_reg;
			run_load <= load_reg;
		end else if (wd_state == WD_COUNTING) begin
			if (ctl.kick) begin
				count <= run_load;
			end else if (count == '0) begin
				wd_state <= WD_FIRED;
			end else begin
				count <= count - CNT_W'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Device reset request
	// ----------------------------------------------------------------
	// Held until the reset controller answers with a warm reset, so a
	// short request can never be missed.
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !warm_rst_b) begin
			reset_req <= REQ_RESET;
		end else if (wd_state == WD_COUNTING && count == '0 && !ctl.kick && !stop_set
			&& !enable_edge) begin
			reset_req <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	logic first_run;
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !warm_rst_b) begin
			first_run <= 1'b0;
		end else if (enable_edge) begin
			first_run <= !first_done;
		end else if (start_ok) begin
			first_run <= 1'b0;
		end
	end

	a_warm_stops: assert property (
		!warm_rst_b |=> (wd_state == WD_STOPPED) && !reset_req
	) else $error("Watchdog not stopped after warm reset.");

	a_poweron_stop: assert property (
		$rose(rst_b) |-> watchdog_stop_bit && !first_done && wd_state == WD_STOPPED
	) else $error("Stop bit or flag wrong after power-on reset.");

	a_clear_starts: assert property (
		enable_edge && !stop_set |=> wd_state == WD_COUNTING && !watchdog_stop_bit
	) else $error("Clearing stop bit did not start watchdog.");

	a_first_default: assert property (
		enable_edge && !first_done |=> count == DEF_LOAD && first_done
	) else $error("First enable did not load default period.");

	a_expire_fires: assert property (
		wd_state == WD_COUNTING && count == '0 && !ctl.kick && !ctl.sec_wr && warm_rst_b
		|=> reset_req && wd_state == WD_FIRED
	) else $error("Expiry did not request device reset.");

	a_stop_kept: assert property (
		!warm_rst_b |=> watchdog_stop_bit == $past(watchdog_stop_bit)
	) else $error("Stop bit changed across warm reset.");

	a_held_stopped: assert property (
		$rose(wd_state == WD_COUNTING) |-> $past(enable_edge) || $past(start_ok)
	) else $error("Watchdog started without enable or restart.");

	a_later_normal: assert property (
		(enable_edge && first_done) || start_ok |=> count == $past(load_reg) && !first_run
	) else $error("Later enable did not use programmed value.");

	a_count_down: assert property (
		wd_state == WD_COUNTING && count != '0 && !ctl.kick && !ctl.sec_wr && warm_rst_b
		|=> count == $past(count) - CNT_W'(1)
	) else $error("Counter did not decrement.");

	a_flag_sticky: assert property (
		first_done |=> first_done
	) else $error("First-enable flag lost without power-on reset.");

	a_flag_follows: assert property (
		!watchdog_stop_bit |-> first_done
	) else $error("Stop bit clear without first-enable flag.");

	a_start_refused: assert property (
		ctl.start && watchdog_stop_bit && !ctl.sec_wr && wd_state == WD_STOPPED
		|=> wd_state == WD_STOPPED
	) else $error("Restart taken while stop bit set.");

	a_kick_reload: assert property (
		wd_state == WD_COUNTING && ctl.kick && !ctl.sec_wr && warm_rst_b
		|=> count == $past(run_load)
	) else $error("Kick did not reload the running period.");

	a_req_held: assert property (
		reset_req && warm_rst_b |=> reset_req
	) else $error("Reset request dropped before warm reset.");

	a_zero_ignored: assert property (
		ctl.load_wr && ctl.load_value == '0 |=> load_reg == $past(load_reg)
	) else $error("Zero timeout was taken.");

	c_first_fire: cover property (first_run && $rose(reset_req));
	c_later_fire: cover property (!first_run && $rose(reset_req));
	c_kick: cover property (wd_state == WD_COUNTING && ctl.kick);
	c_restart: cover property (start_ok);

endmodule : system_watchdog

/* rtl/watchdog_pkg.sv */
// Shared constants and types for the system watchdog.
package watchdog_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS      = 20;
	localparam int unsigned DEFAULT_TIMEOUT_US = 2000;
	localparam int unsigned DEFAULT_TIMEOUT_CYCLES =
		(DEFAULT_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W          = 32;
	localparam logic        STOP_BIT_RESET = 1'b1;
	localparam logic        FIRST_RESET    = 1'b0;
	localparam logic        REQ_RESET      = 1'b0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WD_STOPPED,
		WD_COUNTING,
		WD_FIRED
	} wd_state_t;

	// Software-side control strobes, all on ref_clk.
	typedef struct packed {
		logic             sec_wr;
		logic             stop_wdata;
		logic             load_wr;
		logic [CNT_W-1:0] load_value;
		logic             start;
		logic             kick;
	} wd_ctl_t;

endpackage : watchdog_pkg

/* bench/tb.sv */
// Self-checking testbench for the system watchdog.
`timescale 1ns/1ns
module tb;
	import watchdog_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int unsigned T = 20;
	logic             ref_clk;
	logic             rst_b;
	logic             warm_rst_b;
	wd_ctl_t          ctl;
	wd_state_t        wd_state;
	logic             watchdog_stop_bit;
	logic             first_done;
	logic [CNT_W-1:0] count;
	logic             reset_req;
	int               failures;
	int               num_checks;
	int               cycles;
	int               seed;
	int               n;

	system_watchdog #(.TIMEOUT_CYCLES(T)) u_system_watchdog (
		.ref_clk(ref_clk), .rst_b(rst_b), .warm_rst_b(warm_rst_b), .ctl(ctl),
		.wd_state(wd_state), .watchdog_stop_bit(watchdog_stop_bit),
		.first_done(first_done), .count(count), .reset_req(reset_req));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	// A hang is cut short well beyond the longest expected run.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			finish_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	function automatic wd_ctl_t mk(input logic sec, input logic wd, input int val,
			input logic st);
		wd_ctl_t c;
		c            = '0;
		c.sec_wr     = sec;
		c.stop_wdata = wd;
		c.load_wr    = (val != 0);
		c.load_value = CNT_W'(val);
		c.start      = st;
		return c;
	endfunction : mk

	// A kick, or a load of zero that must be ignored.
	function automatic wd_ctl_t side_ctl(input logic kk, input logic zl);
		wd_ctl_t c;
		c         = '0;
		c.kick    = kk;
		c.load_wr = zl;
		return c;
	endfunction : side_ctl

	// Counter value just after a run of k cycles is armed.
	function automatic logic [31:0] exp_load(input int k);
		return 32'(k - 1);
	endfunction : exp_load

	// Presents one request for a single cycle; returns just after the edge that takes it.
	task automatic pulse(input wd_ctl_t c);
		@(posedge ref_clk);
		ctl <= c;
		@(posedge ref_clk);
		ctl <= '0;
		#1;
	endtask : pulse

	task automatic fire(input int k);
		chk("count at start", count, exp_load(k));
		repeat (k - 1) @(posedge ref_clk);
		#1;
		chk("reset_req early", 32'(reset_req), 32'h0);
		chk("count at zero", count, 32'h0);
		@(posedge ref_clk);
		#1;
		chk("reset_req fired", 32'(reset_req), 32'h1);
		chk("state fired", 32'(wd_state), 32'(WD_FIRED));
	endtask : fire

	task automatic warm();
		@(posedge ref_clk);
		warm_rst_b <= 1'b0;
		@(posedge ref_clk);
		warm_rst_b <= 1'b1;
		#1;
		chk("stop bit after warm", 32'(watchdog_stop_bit), 32'h0);
		chk("first_done after warm", 32'(first_done), 32'h1);
		chk("state after warm", 32'(wd_state), 32'(WD_STOPPED));
		chk("reset_req after warm", 32'(reset_req), 32'h0);
	endtask : warm

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 50582;
		failures = 0;
		num_checks = 0;
		cycles = 0;
		ctl = '0;
		rst_b = 1'b0;
		warm_rst_b = 1'b1;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk("stop bit at reset", 32'(watchdog_stop_bit), 32'h1);
		chk("first_done at reset", 32'(first_done), 32'h0);
		// A start while stopped by the stop bit must be ignored.
		pulse(mk(1'b0, 1'b0, 7 + ($random(seed) & 63), 1'b0));
		pulse(mk(1'b0, 1'b0, 0, 1'b1));
		chk("state refused start", 32'(wd_state), 32'(WD_STOPPED));
		// Enable once early and accept the restart that follows.
		pulse(mk(1'b1, 1'b0, 0, 1'b0));
		chk("stop bit cleared", 32'(watchdog_stop_bit), 32'h0);
		chk("first_done set", 32'(first_done), 32'h1);
		fire(T);
		warm();
		// Rewriting a clear stop bit, with a start beside it, must not restart.
		pulse(mk(1'b1, 1'b0, 0, 1'b1));
		repeat (T + 5) @(posedge ref_clk);
		#1;
		chk("held stopped", 32'(wd_state), 32'(WD_STOPPED));
		for (int i = 0; i < 2; i++) begin
			n = 5 + ($random(seed) & 31);
			pulse(mk(1'b0, 1'b0, n, 1'b0));
			pulse(side_ctl(1'b0, 1'b1));
			pulse(mk(1'b0, 1'b0, 0, 1'b1));
			pulse(mk(1'b0, 1'b0, 0, 1'b1));
			chk("count after refused start", count, exp_load(n) - 32'd2);
			pulse(side_ctl(1'b1, 1'b0));
			fire(n);
			warm();
		end
		// Stop a running count, then enable again with the programmed period.
		pulse(mk(1'b0, 1'b0, 0, 1'b1));
		pulse(mk(1'b1, 1'b1, 0, 1'b0));
		chk("stopped by bit", 32'(wd_state), 32'(WD_STOPPED));
		pulse(mk(1'b1, 1'b0, 0, 1'b0));
		fire(n);
		@(posedge ref_clk);
		rst_b <= 1'b0;
		@(posedge ref_clk);
		rst_b <= 1'b1;
		#1;
		chk("first_done cleared", 32'(first_done), 32'h0);
		chk("stop bit set", 32'(watchdog_stop_bit), 32'h1);
		finish_test();
	end
endmodule : tb
